// File: core/port_bcd_pkg.sv
// Shared constants and carrier types for the port B/C/D pin multiplexer
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package port_bcd_pkg;

    localparam int SEL_W = 2;
    localparam logic [SEL_W-1:0] SEL_GPIO = 2'h0;
    localparam logic [SEL_W-1:0] SEL_ALT1 = 2'h1;
    localparam logic [SEL_W-1:0] SEL_ALT2 = 2'h2;
    localparam logic [SEL_W-1:0] SEL_ALT3 = 2'h3;

    // Pin positions in the pad vectors
    localparam int PIN_COUNT = 11;
    localparam int PB3 = 0;
    localparam int PB5 = 1;
    localparam int PB6 = 2;
    localparam int PB7 = 3;
    localparam int PC0 = 4;
    localparam int PC2 = 5;
    localparam int PC3 = 6;
    localparam int PC4 = 7;
    localparam int PC6 = 8;
    localparam int PC7 = 9;
    localparam int PD5 = 10;

    localparam logic I2C_IDLE = 1'h1;
    localparam logic TEST_RESET_N = 1'h1;
    localparam int TAP_RESET_EDGES = 5;

    typedef struct packed {
        logic [SEL_W-1:0] b3;
        logic [SEL_W-1:0] b5;
        logic [SEL_W-1:0] b6;
        logic [SEL_W-1:0] b7;
        logic [SEL_W-1:0] c0;
        logic [SEL_W-1:0] c2;
        logic [SEL_W-1:0] c3;
        logic [SEL_W-1:0] c4;
        logic [SEL_W-1:0] c6;
        logic [SEL_W-1:0] c7;
    } sel_type;

    localparam sel_type SEL_RESET = '{default: SEL_GPIO};

    typedef struct packed {
        logic [PIN_COUNT-1:0] dir;
        logic [PIN_COUNT-1:0] dout;
    } port_ctrl_type;

    typedef struct packed {
        logic spi_master_out_0;
        logic timer_chan_3_out;
        logic timer_chan_3_oe;
        logic timer_chan_1_out;
        logic timer_chan_1_oe;
        logic serial_tx_0;
        logic i2c_sda_low;
        logic i2c_scl_low;
    } periph_out_type;

    typedef struct packed {
        logic timer_chan_3_in;
        logic pwm_source_1;
        logic timer_chan_1_in;
        logic pwm_fault_in_3;
        logic serial_rx_0;
        logic i2c_sda_in;
        logic i2c_scl_in;
        logic ext_clock_input;
    } periph_in_type;

    typedef struct packed {
        logic adc_a_in0;
        logic cmp_a_in3;
        logic adc_a_in2;
        logic adc_a_ref_high;
        logic adc_a_in3;
        logic adc_a_ref_low;
        logic adc_b_in0;
        logic cmp_b_in3;
        logic adc_b_in2;
        logic adc_b_ref_high;
        logic adc_b_in3;
        logic adc_b_ref_low;
        logic crystal_out;
    } analog_conn_type;

    typedef enum logic [15:0] {
        TAP_RESET  = 16'h0001,
        TAP_IDLE   = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SH_DR  = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PA_DR  = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SH_IR  = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PA_IR  = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } tap_state_type;

endpackage

// File: core/tap_reset_ctrl.sv
// Test access port state tracker with power-on and TMS soft reset
`timescale 1ns/1ps
`default_nettype none
module tap_reset_ctrl import port_bcd_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Synchronised test port pins
    input wire logic tck_s,
    input wire logic tms_s,
    // State
    output logic tap_in_reset
);
    tap_state_type state_r, state_nxt;
    logic tck_d_r;
    logic tck_rise;

    assign tck_rise = tck_s & ~tck_d_r;

    always_comb begin
        state_nxt = state_r;
        if (tck_rise) begin
            case (state_r)
                TAP_RESET:  state_nxt = tms_s ? TAP_RESET : TAP_IDLE;
                TAP_IDLE:   state_nxt = tms_s ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR: state_nxt = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: state_nxt = tms_s ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR:  state_nxt = tms_s ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: state_nxt = tms_s ? TAP_UPD_DR : TAP_PA_DR;
                TAP_PA_DR:  state_nxt = tms_s ? TAP_EX2_DR : TAP_PA_DR;
                TAP_EX2_DR: state_nxt = tms_s ? TAP_UPD_DR : TAP_SH_DR;
                TAP_UPD_DR: state_nxt = tms_s ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR: state_nxt = tms_s ? TAP_RESET : TAP_CAP_IR;
                TAP_CAP_IR: state_nxt = tms_s ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR:  state_nxt = tms_s ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: state_nxt = tms_s ? TAP_UPD_IR : TAP_PA_IR;
                TAP_PA_IR:  state_nxt = tms_s ? TAP_EX2_IR : TAP_PA_IR;
                TAP_EX2_IR: state_nxt = tms_s ? TAP_UPD_IR : TAP_SH_IR;
                TAP_UPD_IR: state_nxt = tms_s ? TAP_SEL_DR : TAP_IDLE;
                default:    state_nxt = TAP_RESET;
            endcase
        end
    end

    // Power-on reset and five TMS-high TCK rises clear the machine: the test reset line is tied inactive
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= TAP_RESET;
            tck_d_r <= 1'h0;
        end else begin
            state_r <= state_nxt;
            tck_d_r <= tck_s;
        end
    end

    assign tap_in_reset = (state_r == TAP_RESET) || !TEST_RESET_N;

    // Helper: run of consecutive TCK rises seen with TMS high, saturating
    logic [2:0] tms_run_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tms_run_r <= 3'h0;
        end else if (tck_rise) begin
            tms_run_r <= !tms_s ? 3'h0 : (tms_run_r == 3'(TAP_RESET_EDGES)) ? tms_run_r : tms_run_r + 3'h1;
        end
    end

    a_tap_soft_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tms_run_r == 3'(TAP_RESET_EDGES)) |-> (state_r == TAP_RESET))
        else $error("TAP not in reset after five TMS-high TCK edges");

    a_tap_por_reset: assert property (@(posedge sys_clk)
        $rose(rst_n) |-> (state_r == TAP_RESET))
        else $error("TAP not in reset on power-on release");

endmodule
`default_nettype wire

// File: core/port_bcd_signal_mux.sv
// Pin multiplexer for upper port B, port C and port D pins with test port reset
`timescale 1ns/1ps
`default_nettype none
module port_bcd_signal_mux import port_bcd_pkg::*; #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Select fields and clock synthesis enable
    input wire sel_type peripheral_select_reg,
    input wire logic [SEL_W-1:0] port_cd_select_reg,
    input wire logic ext_clock_input_enable,
    // Port register bits
    input wire port_ctrl_type port_ctrl,
    // Package pins
    input wire logic [PIN_COUNT-1:0] pad_in,
    output logic [PIN_COUNT-1:0] pad_out,
    output logic [PIN_COUNT-1:0] pad_oe,
    input wire logic tck_pin,
    input wire logic tms_pin,
    // Peripheral side
    input wire periph_out_type periph_out,
    output periph_in_type periph_in,
    output analog_conn_type analog_conn,
    output logic [PIN_COUNT-1:0] gpio_in,
    output logic tap_reset_state
);
    //--------------------------------------------------------------------------
    // Elaboration checks
    //--------------------------------------------------------------------------
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    //--------------------------------------------------------------------------
    // Reset release and pin synchronisers
    //--------------------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Pads and test pins are asynchronous; nothing reads a stage before the last
    logic [PIN_COUNT+1:0] sync_r [SYNC_STAGES];
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                sync_r[i] <= '0;
            end
        end else begin
            sync_r[0] <= {tms_pin, tck_pin, pad_in};
            for (int i = 1; i < SYNC_STAGES; i++) begin
                sync_r[i] <= sync_r[i-1];
            end
        end
    end

    logic [PIN_COUNT-1:0] pin_s;
    logic tck_s;
    logic tms_s;
    assign pin_s = sync_r[SYNC_STAGES-1][PIN_COUNT-1:0];
    assign tck_s = sync_r[SYNC_STAGES-1][PIN_COUNT];
    assign tms_s = sync_r[SYNC_STAGES-1][PIN_COUNT+1];

    //--------------------------------------------------------------------------
    // Select capture
    //--------------------------------------------------------------------------
    sel_type sel_r, sel_nxt;
    logic [SEL_W-1:0] sel_d5_r, sel_d5_nxt;
    logic clk_en_r, clk_en_nxt;

    always_comb begin
        sel_nxt = peripheral_select_reg;
        sel_d5_nxt = port_cd_select_reg;
        clk_en_nxt = ext_clock_input_enable;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= SEL_RESET;
            sel_d5_r <= SEL_GPIO;
            clk_en_r <= 1'h0;
        end else begin
            sel_r <= sel_nxt;
            sel_d5_r <= sel_d5_nxt;
            clk_en_r <= clk_en_nxt;
        end
    end

    function automatic logic [SEL_W-1:0] pin_sel(input sel_type s, input logic [SEL_W-1:0] d5, input int idx);
        case (idx)
            PB3: return s.b3;
            PB5: return s.b5;
            PB6: return s.b6;
            PB7: return s.b7;
            PC0: return s.c0;
            PC2: return s.c2;
            PC3: return s.c3;
            PC4: return s.c4;
            PC6: return s.c6;
            PC7: return s.c7;
            PD5: return d5;
            default: return SEL_GPIO;
        endcase
    endfunction

    //--------------------------------------------------------------------------
    // Routing
    //--------------------------------------------------------------------------
    logic [PIN_COUNT-1:0] pad_out_r, pad_out_nxt;
    logic [PIN_COUNT-1:0] pad_oe_r, pad_oe_nxt;
    logic [PIN_COUNT-1:0] gpio_in_r, gpio_in_nxt;
    periph_in_type periph_in_r, periph_in_nxt;
    analog_conn_type analog_r, analog_nxt;

    always_comb begin
        pad_out_nxt = '0;
        pad_oe_nxt = '0;
        gpio_in_nxt = '0;
        periph_in_nxt = '0;
        periph_in_nxt.i2c_sda_in = I2C_IDLE;
        periph_in_nxt.i2c_scl_in = I2C_IDLE;
        analog_nxt = '0;

        // A pin chosen as general-purpose answers to port bits only
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (pin_sel(sel_r, sel_d5_r, i) == SEL_GPIO) begin
                pad_oe_nxt[i] = port_ctrl.dir[i];
                pad_out_nxt[i] = port_ctrl.dout[i];
                gpio_in_nxt[i] = pin_s[i];
            end
        end

        // Port B bit 3
        case (sel_r.b3)
            SEL_ALT1: begin
                pad_oe_nxt[PB3] = 1'h1;
                pad_out_nxt[PB3] = periph_out.spi_master_out_0;
            end
            SEL_ALT2: begin
                pad_oe_nxt[PB3] = periph_out.timer_chan_3_oe;
                pad_out_nxt[PB3] = periph_out.timer_chan_3_out;
                periph_in_nxt.timer_chan_3_in = pin_s[PB3];
            end
            SEL_ALT3: periph_in_nxt.pwm_source_1 = pin_s[PB3];
            default: ;
        endcase

        // Port B bit 5
        case (sel_r.b5)
            SEL_ALT1: begin
                pad_oe_nxt[PB5] = periph_out.timer_chan_1_oe;
                pad_out_nxt[PB5] = periph_out.timer_chan_1_out;
                periph_in_nxt.timer_chan_1_in = pin_s[PB5];
            end
            SEL_ALT2: periph_in_nxt.pwm_fault_in_3 = pin_s[PB5];
            default: ;
        endcase

        // Port B bit 6
        case (sel_r.b6)
            SEL_ALT1: periph_in_nxt.serial_rx_0 = pin_s[PB6];
            SEL_ALT2: begin
                pad_oe_nxt[PB6] = periph_out.i2c_sda_low;
                periph_in_nxt.i2c_sda_in = pin_s[PB6];
            end
            default: ;
        endcase

        // Port B bit 7; the I2C line is open drain and only ever pulled low
        case (sel_r.b7)
            SEL_ALT1: begin
                pad_oe_nxt[PB7] = 1'h1;
                pad_out_nxt[PB7] = periph_out.serial_tx_0;
            end
            SEL_ALT2: begin
                pad_oe_nxt[PB7] = periph_out.i2c_scl_low;
                periph_in_nxt.i2c_scl_in = pin_s[PB7];
            end
            default: ;
        endcase

        // Analog connections leave the digital driver off
        analog_nxt.adc_a_in0 = (sel_r.c0 == SEL_ALT1);
        analog_nxt.cmp_a_in3 = (sel_r.c0 == SEL_ALT2);
        analog_nxt.adc_a_in2 = (sel_r.c2 == SEL_ALT1);
        analog_nxt.adc_a_ref_high = (sel_r.c2 == SEL_ALT2);
        analog_nxt.adc_a_in3 = (sel_r.c3 == SEL_ALT1);
        analog_nxt.adc_a_ref_low = (sel_r.c3 == SEL_ALT2);
        analog_nxt.adc_b_in0 = (sel_r.c4 == SEL_ALT1);
        analog_nxt.cmp_b_in3 = (sel_r.c4 == SEL_ALT2);
        analog_nxt.adc_b_in2 = (sel_r.c6 == SEL_ALT1);
        analog_nxt.adc_b_ref_high = (sel_r.c6 == SEL_ALT2);
        analog_nxt.adc_b_in3 = (sel_r.c7 == SEL_ALT1);
        analog_nxt.adc_b_ref_low = (sel_r.c7 == SEL_ALT2);
        analog_nxt.crystal_out = (sel_d5_r == SEL_ALT1);

        // Clock input from any pin routed to it, held off until enabled
        periph_in_nxt.ext_clock_input = clk_en_r & (((sel_r.b5 == SEL_ALT3) & pin_s[PB5]) |
                                                     ((sel_r.b6 == SEL_ALT3) & pin_s[PB6]) |
                                                     ((sel_d5_r == SEL_ALT2) & pin_s[PD5]));
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out_r <= '0;
            pad_oe_r <= '0;
            gpio_in_r <= '0;
            periph_in_r <= '0;
            analog_r <= '0;
        end else begin
            pad_out_r <= pad_out_nxt;
            pad_oe_r <= pad_oe_nxt;
            gpio_in_r <= gpio_in_nxt;
            periph_in_r <= periph_in_nxt;
            analog_r <= analog_nxt;
        end
    end

    assign pad_out = pad_out_r;
    assign pad_oe = pad_oe_r;
    assign gpio_in = gpio_in_r;
    assign periph_in = periph_in_r;
    assign analog_conn = analog_r;

    //--------------------------------------------------------------------------
    // Test port
    //--------------------------------------------------------------------------
    tap_reset_ctrl u_tap (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tck_s(tck_s),
        .tms_s(tms_s),
        .tap_in_reset(tap_reset_state)
    );

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    a_b3_gpio_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_r.b3 == SEL_GPIO) |=> (pad_oe[PB3] == $past(port_ctrl.dir[PB3]))
                                   && (pad_out[PB3] == $past(port_ctrl.dout[PB3])))
        else $error("B3 general-purpose drive mismatch");

    a_b5_fault_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_r.b5 == SEL_ALT2) |=> (periph_in.pwm_fault_in_3 == $past(pin_s[PB5])) && !pad_oe[PB5])
        else $error("B5 fault input not routed");

    a_ext_clock_input_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !clk_en_r |=> !periph_in.ext_clock_input)
        else $error("Clock input active while disabled");

    a_b6_rx_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_r.b6 == SEL_ALT1) |=> (periph_in.serial_rx_0 == $past(pin_s[PB6])) && !pad_oe[PB6])
        else $error("B6 receive not routed");

    a_b7_scl_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_r.b7 == SEL_ALT2) |=> (pad_oe[PB7] == $past(periph_out.i2c_scl_low)) && !pad_out[PB7])
        else $error("B7 open-drain clock drive wrong");

    a_c0_adc_conn: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_r.c0 == SEL_ALT1) |=> analog_conn.adc_a_in0 && !analog_conn.cmp_a_in3 && !pad_oe[PC0])
        else $error("C0 ADC connection wrong");

    a_c3_ref_conn: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_r.c3 == SEL_ALT2) |=> analog_conn.adc_a_ref_low && !analog_conn.adc_a_in3 && !gpio_in[PC3])
        else $error("C3 reference connection wrong");

    a_c4_cmp_conn: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_r.c4 == SEL_ALT2) |=> analog_conn.cmp_b_in3 && !analog_conn.adc_b_in0)
        else $error("C4 comparator connection wrong");

    a_c6_ref_conn: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_r.c6 == SEL_ALT2) |=> analog_conn.adc_b_ref_high && !pad_oe[PC6])
        else $error("C6 reference connection wrong");

    a_d5_clk_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_d5_r == SEL_ALT2) && clk_en_r |=> (periph_in.ext_clock_input == $past(pin_s[PD5]))
                                            || ($past(sel_r.b5) == SEL_ALT3) || ($past(sel_r.b6) == SEL_ALT3))
        else $error("D5 clock input not routed");

    a_sel_reset: assert property (@(posedge sys_clk)
        $rose(rst_n) |-> (sel_r == SEL_RESET) && (sel_d5_r == SEL_GPIO))
        else $error("Select fields not general-purpose after reset");

endmodule
`default_nettype wire

// File: sim/tap_tester.sv
// External test port driver for the pin multiplexer bench
`timescale 1ns/1ps
`default_nettype none
module tap_tester (
    // Clock
    input wire logic sys_clk,
    // Test port pins
    output logic tck_pin,
    output logic tms_pin
);
    // There is no test reset pin, so apart from power-on reset TMS is the only way to reset the port
    initial begin
        tck_pin = 1'b0;
        tms_pin = 1'b1;
    end
    // One TCK rise; levels held three clocks so the synchroniser sees each one
    task automatic tick(input logic tms);
        tms_pin = tms;
        repeat (3) @(negedge sys_clk);
        tck_pin = 1'b1;
        repeat (3) @(negedge sys_clk);
        tck_pin = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: sim/port_bcd_signal_mux_bench.sv
// Self-checking bench for the port B/C/D pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module port_bcd_signal_mux_bench import port_bcd_pkg::*;;
    localparam int OUT = 44, OE = 33, GI = 22, PI = 14, AN = 1;
    typedef struct {int due; logic [54:0] m; logic [54:0] e;} note_type;
    note_type q[$];
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    sel_type sel = SEL_RESET;
    logic [1:0] cdsel = 2'h0;
    logic clk_en = 1'b0;
    port_ctrl_type ctrl = '0;
    logic [10:0] pad = 11'h000;
    periph_out_type pout = '0;
    logic [10:0] pad_out, pad_oe, gpio_in;
    periph_in_type periph_in;
    analog_conn_type analog_conn;
    logic tap_reset_state;
    wire logic tck, tms;
    wire logic [54:0] obs = {pad_out, pad_oe, gpio_in, periph_in, analog_conn, tap_reset_state};
    int cyc = 0;
    int errors = 0;
    int samples_checked = 0;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    port_bcd_signal_mux #(.SYNC_STAGES(2)) uut (.sys_clk(sys_clk), .resetn(resetn),
        .peripheral_select_reg(sel), .port_cd_select_reg(cdsel), .ext_clock_input_enable(clk_en),
        .port_ctrl(ctrl), .pad_in(pad), .pad_out(pad_out), .pad_oe(pad_oe), .tck_pin(tck),
        .tms_pin(tms), .periph_out(pout), .periph_in(periph_in), .analog_conn(analog_conn),
        .gpio_in(gpio_in), .tap_reset_state(tap_reset_state));
    tap_tester tt (.sys_clk(sys_clk), .tck_pin(tck), .tms_pin(tms));
    function automatic logic [54:0] b(input int i);
        return 55'h1 << i;
    endfunction
    task automatic check(input logic [54:0] seen, input logic [54:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic note(input logic [54:0] m, input logic [54:0] e);
        q.push_back(note_type'{cyc + 1, m, e});
    endtask
    // Every route settles within five edges, so one wait serves all cases
    task automatic settle(input logic [54:0] m, input logic [54:0] e);
        repeat (6) @(negedge sys_clk);
        note(m, e);
        @(negedge sys_clk);
    endtask
    task automatic alt(input int f, input logic [1:0] c, input logic [7:0] po, input logic [10:0] pi,
                       input logic en, input logic [54:0] m, input logic [54:0] e);
        sel_type s;
        s = SEL_RESET;
        s[19 - 2 * f -: 2] = c;
        @(negedge sys_clk);
        sel = s;
        pout = po;
        pad = pi;
        clk_en = en;
        settle(m, e);
    endtask
    task automatic do_reset();
        @(negedge sys_clk);
        resetn = 1'b0;
        sel = SEL_RESET;
        cdsel = 2'h0;
        clk_en = 1'b0;
        ctrl = '0;
        pad = 11'h000;
        pout = '0;
        repeat (4) @(negedge sys_clk);
        note(b(0), b(0));
        repeat (12) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        note(~55'h0, b(0) | b(PI + 1) | b(PI + 2));
        @(negedge sys_clk);
    endtask
    task automatic tk(input logic t);
        tt.tick(t);
        repeat (2) @(negedge sys_clk);
    endtask
    // Comparison side: takes the oldest note once its cycle has come
    always @(negedge sys_clk) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            check(obs & q[0].m, q[0].e);
            void'(q.pop_front());
        end
    end
    // The whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        end_sim();
    end
    initial begin
        void'($urandom(18043));
        do_reset();
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            ctrl = port_ctrl_type'(22'($urandom));
            pad = 11'($urandom);
            settle({ctrl.dir, 22'h3fffff, 22'h0}, {ctrl.dout & ctrl.dir, ctrl.dir, pad, 22'h0});
        end
        ctrl = '0;
        $display("test gpio done");
        alt(0, 2'h1, 8'h80, 11'h000, 1'b0, b(OUT) | b(OE), b(OUT) | b(OE));
        alt(0, 2'h2, 8'h60, 11'h001, 1'b0, b(OUT) | b(OE) | b(PI + 7), b(OUT) | b(OE) | b(PI + 7));
        alt(0, 2'h3, 8'h00, 11'h001, 1'b0, b(PI + 6) | b(OE), b(PI + 6));
        alt(1, 2'h1, 8'h18, 11'h002, 1'b0, b(OUT + 1) | b(OE + 1) | b(PI + 5), b(OUT + 1) | b(OE + 1) | b(PI + 5));
        alt(1, 2'h2, 8'h00, 11'h002, 1'b0, b(PI + 4), b(PI + 4));
        alt(1, 2'h3, 8'h00, 11'h002, 1'b0, b(PI), 55'h0);
        alt(1, 2'h3, 8'h00, 11'h002, 1'b1, b(PI), b(PI));
        alt(2, 2'h1, 8'h00, 11'h004, 1'b0, b(PI + 3), b(PI + 3));
        alt(2, 2'h2, 8'h02, 11'h000, 1'b0, b(OUT + 2) | b(OE + 2) | b(PI + 2), b(OE + 2));
        alt(2, 2'h3, 8'h00, 11'h004, 1'b1, b(PI), b(PI));
        alt(3, 2'h1, 8'h04, 11'h000, 1'b0, b(OUT + 3) | b(OE + 3), b(OUT + 3) | b(OE + 3));
        alt(3, 2'h2, 8'h01, 11'h000, 1'b0, b(OUT + 3) | b(OE + 3) | b(PI + 1), b(OE + 3));
        ctrl = '{dir: 11'h7ff, dout: 11'h000};
        // Pads held high so a leak into the general-purpose input would show
        for (int k = 0; k < 6; k++) begin
            for (int c = 1; c < 3; c++) begin
                alt(k + 4, 2'(c), 8'h00, 11'h7ff, 1'b0, b(AN + 13 - 2 * k - c) | b(OE + 4 + k) | b(GI + 4 + k),
                    b(AN + 13 - 2 * k - c));
            end
        end
        alt(0, 2'h0, 8'h00, 11'h000, 1'b0, b(OE + 4), b(OE + 4));
        @(negedge sys_clk);
        cdsel = 2'h1;
        settle(b(AN) | b(OE + 10), b(AN));
        cdsel = 2'h2;
        pad = 11'h400;
        clk_en = 1'b1;
        settle(b(PI), b(PI));
        $display("test routes done");
        for (int i = 3; i >= 0; i--) tk(i == 2);
        note(b(0), 55'h0);
        for (int i = 0; i < 5; i++) begin
            tk(1'b1);
            note(b(0), (i == 4) ? b(0) : 55'h0);
        end
        tk(1'b0);
        note(b(0), 55'h0);
        do_reset();
        $display("test tap done");
        repeat (3) @(negedge sys_clk);
        end_sim();
    end
endmodule
`default_nettype wire
